/* psic_core.sv */
// Program counter, circular return stack and interrupt control of a
// small 8-bit core, with an Avalon-MM register slave.
// Assumes decode logic and event sources run on the same clock and
// give at most one program counter command per cycle by priority.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns

module psic_core
  import psic_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [psic_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic core_step,
  input wire logic core_call,
  input wire logic core_jump,
  input wire logic core_return,
  input wire logic core_return_from_interrupt,
  input wire logic core_vector,
  input wire logic [psic_pkg::TARGET_W-1:0] core_target,
  input wire logic core_pcl_we,
  input wire logic [psic_pkg::DATA_W-1:0] core_pcl_data,
  input wire logic timer_overflow_event,
  input wire logic ext_pin_event,
  input wire logic pin_change_event,
  input wire logic [psic_pkg::DATA_W-1:0] periph_events,
  output logic [psic_pkg::PC_W-1:0] pc,
  output logic irq_request
);
  import psic_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] interrupt_control;
  logic [DATA_W-1:0] peripheral_irq_flags;
  logic [DATA_W-1:0] peripheral_irq_enables;
  logic [LATCH_W-1:0] pc_high_latch;
  logic [EVT_W-1:0] event_status;
  logic [EVT_W-1:0] event_mask;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] sp;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [7:0] reg_idx = avs_address[ADDR_W-1:2];
  wire bus_req = avs_read | avs_write;
  wire wr_fire = avs_write & ~avs_waitrequest;
  wire [DATA_W-1:0] wdata = avs_writedata[DATA_W-1:0];
  wire wr_pcl = wr_fire & (reg_idx == IDX_PC_LOW);
  wire wr_latch = wr_fire & (reg_idx == IDX_PC_HIGH_LATCH);
  wire wr_interrupt_control = wr_fire & (reg_idx == IDX_INTERRUPT_CONTROL);
  wire wr_pir = wr_fire & (reg_idx == IDX_PERIPHERAL_IRQ_FLAGS);
  wire wr_pie = wr_fire & (reg_idx == IDX_PERIPHERAL_IRQ_ENABLES);
  wire wr_status = wr_fire & (reg_idx == IDX_EVENT_STATUS);
  wire wr_mask = wr_fire & (reg_idx == IDX_EVENT_MASK);

  // Read selection, unmapped words read as zero
  wire [7:0] rd_byte =
    (reg_idx == IDX_PC_LOW) ? pc[7:0] :
    (reg_idx == IDX_PC_HIGH_LATCH) ? {3'h0, pc_high_latch} :
    (reg_idx == IDX_INTERRUPT_CONTROL) ? interrupt_control :
    (reg_idx == IDX_PERIPHERAL_IRQ_FLAGS) ? peripheral_irq_flags :
    (reg_idx == IDX_PERIPHERAL_IRQ_ENABLES) ? peripheral_irq_enables :
    (reg_idx == IDX_EVENT_STATUS) ? {6'h00, event_status} :
    (reg_idx == IDX_EVENT_MASK) ? {6'h00, event_mask} : 8'h00;

  // ----------------------------------------------------------------
  // Program counter command selection
  // ----------------------------------------------------------------
  wire any_return = core_return | core_return_from_interrupt;
  wire pcl_we = core_pcl_we | wr_pcl;
  wire [DATA_W-1:0] pcl_data = core_pcl_we ? core_pcl_data : wdata;
  psic_op_t op;
  assign op = core_vector ? OP_VECTOR :
              core_call ? OP_CALL :
              core_jump ? OP_JUMP :
              any_return ? OP_RET :
              pcl_we ? OP_PCL :
              core_step ? OP_STEP : OP_NONE;

  wire push_en = (op == OP_VECTOR) | (op == OP_CALL);
  wire pop_en = (op == OP_RET);
  wire vector_fire = (op == OP_VECTOR);
  wire return_from_interrupt_fire = pop_en & core_return_from_interrupt;
  wire [SP_W-1:0] sp_dec = sp - 3'h1;
  wire [SP_W-1:0] sp_inc = sp + 3'h1;
  // Paging bits masked off, calls and jumps reach the first page only
  wire [1:0] page_bits = pc_high_latch[4:3] & PAGE_KEEP_MASK;
  wire [PC_W-1:0] branch_pc = {page_bits, core_target};
  wire [PC_W-1:0] pcl_pc = {pc_high_latch, pcl_data};

  // Next program counter
  logic [PC_W-1:0] next_pc;
  always_comb begin
    case (op)
      OP_VECTOR: next_pc = IRQ_VECTOR_ADDR;
      OP_CALL, OP_JUMP: next_pc = branch_pc;
      OP_RET: next_pc = stack_mem[sp_dec];
      OP_PCL: next_pc = pcl_pc;
      OP_STEP: next_pc = pc + 13'h0001;
      default: next_pc = pc;
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt control, hardware set wins over software write
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] core_set = {5'h00, timer_overflow_event,
                                ext_pin_event, pin_change_event};
  logic [DATA_W-1:0] interrupt_control_base;
  always_comb begin
    interrupt_control_base = wr_interrupt_control ? wdata : interrupt_control;
    if (vector_fire) begin
      interrupt_control_base[GLOBAL_IRQ_ENABLE_BIT] = 1'b0;
    end
    if (return_from_interrupt_fire) begin
      interrupt_control_base[GLOBAL_IRQ_ENABLE_BIT] = 1'b1;
    end
  end
  wire [DATA_W-1:0] next_interrupt_control = interrupt_control_base | core_set;
  wire [DATA_W-1:0] next_pir =
    (wr_pir ? wdata : peripheral_irq_flags) | periph_events;

  wire global_irq_enable = interrupt_control[GLOBAL_IRQ_ENABLE_BIT];
  wire peripheral_irq_enable = interrupt_control[PERIPHERAL_IRQ_ENABLE_BIT];
  wire core_hit =
    (interrupt_control[TIMER_OVERFLOW_IRQ_ENABLE_BIT] &
     interrupt_control[TIMER_OVERFLOW_FLAG_BIT]) |
    (interrupt_control[EXT_PIN_IRQ_ENABLE_BIT] &
     interrupt_control[EXT_PIN_IRQ_FLAG_BIT]) |
    (interrupt_control[PIN_CHANGE_IRQ_ENABLE_BIT] &
     interrupt_control[PIN_CHANGE_FLAG_BIT]);
  wire periph_hit =
    peripheral_irq_enable & |(peripheral_irq_flags & peripheral_irq_enables);
  wire next_irq_request = global_irq_enable & (core_hit | periph_hit);

  // Block events, write one to clear, set wins
  wire [EVT_W-1:0] evt_in = {return_from_interrupt_fire, vector_fire};
  wire [EVT_W-1:0] evt_clr = wr_status ? wdata[EVT_W-1:0] : RST_EVENT;
  wire [EVT_W-1:0] next_event_status = (event_status & ~evt_clr) | evt_in;

  // ----------------------------------------------------------------
  // Bus handshake, one wait cycle then the answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Program counter, cleared on every reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= RST_PC;
    end else begin
      pc <= next_pc;
    end
  end

  // Stack pointer, wraps around, no overflow flag kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp <= RST_SP;
    end else if (push_en) begin
      sp <= sp_inc;
    end else if (pop_en) begin
      sp <= sp_dec;
    end
  end

  // Stack storage, not mapped on the bus
  always_ff @(posedge clk) begin
    if (push_en) begin
      stack_mem[sp] <= pc;
    end
  end

  // High latch, changed only by a bus write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_high_latch <= RST_PC_HIGH_LATCH;
    end else if (wr_latch) begin
      pc_high_latch <= wdata[LATCH_W-1:0];
    end
  end

  // Interrupt registers and request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_control <= RST_INTERRUPT_CONTROL;
      peripheral_irq_flags <= RST_PERIPHERAL_IRQ_FLAGS;
      peripheral_irq_enables <= RST_PERIPHERAL_IRQ_ENABLES;
      irq_request <= 1'b0;
    end else begin
      interrupt_control <= next_interrupt_control;
      peripheral_irq_flags <= next_pir;
      if (wr_pie) begin
        peripheral_irq_enables <= wdata;
      end
      irq_request <= next_irq_request;
    end
  end

  // Event status, mask and interrupt line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_status <= RST_EVENT;
      event_mask <= RST_EVENT;
      irq <= 1'b0;
    end else begin
      event_status <= next_event_status;
      if (wr_mask) begin
        event_mask <= wdata[EVT_W-1:0];
      end
      irq <= |(next_event_status & event_mask);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_gie_blocks;
    !global_irq_enable |=> !irq_request;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks)
    else $error("request raised with global enable clear");

  property p_peripheral_irq_enable_gates;
    (!peripheral_irq_enable && !core_hit) |=> !irq_request;
  endproperty
  a_peripheral_irq_enable_gates: assert property (p_peripheral_irq_enable_gates)
    else $error("peripheral request passed with peripheral enable clear");

  // Flag must read set on the cycle after its event
  property p_flag_sets;
    timer_overflow_event |=> interrupt_control[TIMER_OVERFLOW_FLAG_BIT];
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("timer overflow flag not set by its event");

  property p_flag_sticky;
    (interrupt_control[EXT_PIN_IRQ_FLAG_BIT] && !wr_interrupt_control) |=>
      interrupt_control[EXT_PIN_IRQ_FLAG_BIT];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("external pin flag cleared without a write");

  property p_pcl_load;
    (op == OP_PCL) |=> pc == {$past(pc_high_latch), $past(pcl_data)};
  endproperty
  a_pcl_load: assert property (p_pcl_load)
    else $error("low byte write loaded wrong program counter");

  property p_branch_load;
    (op == OP_CALL || op == OP_JUMP) |=>
      pc == {2'h0, $past(core_target)};
  endproperty
  a_branch_load: assert property (p_branch_load)
    else $error("branch loaded wrong program counter");

  property p_call_return;
    (op == OP_CALL) ##1 (op == OP_RET) |=> pc == $past(pc, 2);
  endproperty
  a_call_return: assert property (p_call_return)
    else $error("return did not restore pushed address");

  property p_latch_kept;
    ((push_en || pop_en) && !wr_latch) |=> $stable(pc_high_latch);
  endproperty
  a_latch_kept: assert property (p_latch_kept)
    else $error("high latch changed by a push or pop");

  property p_wrap;
    (push_en && sp == 3'h7) |=> sp == 3'h0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("stack pointer did not wrap");

  property p_vector;
    vector_fire |=> pc == IRQ_VECTOR_ADDR && !global_irq_enable;
  endproperty
  a_vector: assert property (p_vector)
    else $error("vectoring did not load the vector address");

  property p_request;
    (global_irq_enable && core_hit) |=> irq_request;
  endproperty
  a_request: assert property (p_request)
    else $error("enabled flag did not raise the request");

  property p_bus_answer;
    (bus_req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not given after one wait cycle");

  // Peripheral events land in their flags whatever the enables
  property p_periph_flag_sets;
    (periph_events != 8'h00) |=>
      (peripheral_irq_flags & $past(periph_events)) ==
        $past(periph_events);
  endproperty
  a_periph_flag_sets: assert property (p_periph_flag_sets)
    else $error("peripheral flag not set by its event");

  property p_step;
    (op == OP_STEP) |=> pc == $past(pc) + 13'h0001;
  endproperty
  a_step: assert property (p_step)
    else $error("step did not advance the program counter");

  // Low byte read returns the counter seen when the read was taken
  property p_readback_pcl;
    (avs_read && !avs_waitrequest && reg_idx == IDX_PC_LOW) |->
      avs_readdata[7:0] == $past(pc[7:0]);
  endproperty
  a_readback_pcl: assert property (p_readback_pcl)
    else $error("low byte read did not return the program counter");

  // Pointer moves one place per push, wrapping freely
  property p_push_moves;
    push_en |=> sp == $past(sp) + 3'h1;
  endproperty
  a_push_moves: assert property (p_push_moves)
    else $error("push did not advance the stack pointer");

  property p_pop_moves;
    pop_en |=> sp == $past(sp) - 3'h1;
  endproperty
  a_pop_moves: assert property (p_pop_moves)
    else $error("pop did not step the stack pointer back");

  // Return from interrupt opens the global enable again
  property p_return_from_interrupt_enables;
    return_from_interrupt_fire |=> global_irq_enable;
  endproperty
  a_return_from_interrupt_enables: assert property (p_return_from_interrupt_enables)
    else $error("return from interrupt left global enable clear");

  property p_request_periph;
    (global_irq_enable && periph_hit) |=> irq_request;
  endproperty
  a_request_periph: assert property (p_request_periph)
    else $error("enabled peripheral flag did not raise the request");

  c_call_return: cover property (p_call_return);
  c_wrap: cover property (push_en && sp == 3'h7);
  c_vector: cover property (vector_fire ##[1:20] return_from_interrupt_fire);
  c_irq: cover property ($rose(irq));
  c_periph: cover property (global_irq_enable && periph_hit);

endmodule : psic_core

/* psic_pkg.sv */
// Constants and types for the program counter, return stack and
// interrupt control block.
// Assumes a single 25 MHz core clock and an Avalon-MM register port.
package psic_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int ADDR_W = 10;
  localparam int LATCH_W = 5;
  localparam int TARGET_W = 11;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PC_LOW = 8'h02;
  localparam logic [7:0] IDX_PC_HIGH_LATCH = 8'h0A;
  localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'hF0;
  localparam logic [7:0] IDX_EVENT_MASK = 8'hF1;

  // ----------------------------------------------------------------
  // Interrupt control field positions
  // ----------------------------------------------------------------
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int TIMER_OVERFLOW_IRQ_ENABLE_BIT = 5;
  localparam int EXT_PIN_IRQ_ENABLE_BIT = 4;
  localparam int PIN_CHANGE_IRQ_ENABLE_BIT = 3;
  localparam int TIMER_OVERFLOW_FLAG_BIT = 2;
  localparam int EXT_PIN_IRQ_FLAG_BIT = 1;
  localparam int PIN_CHANGE_FLAG_BIT = 0;

  // Event status field positions
  localparam int EVT_VECTOR_BIT = 0;
  localparam int EVT_RETURN_IRQ_BIT = 1;
  localparam int EVT_W = 2;

  // ----------------------------------------------------------------
  // Reset values and fixed addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLES = 8'h00;
  localparam logic [4:0] RST_PC_HIGH_LATCH = 5'h00;
  localparam logic [1:0] RST_EVENT = 2'h0;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic [2:0] RST_SP = 3'h0;
  localparam logic [12:0] IRQ_VECTOR_ADDR = 13'h0004;
  localparam logic [1:0] PAGE_KEEP_MASK = 2'h0;

  // Program counter operation of one cycle, OP_NONE first, then the rest highest priority first
  typedef enum logic [2:0] {
    OP_NONE, OP_VECTOR, OP_CALL, OP_JUMP, OP_RET, OP_PCL, OP_STEP
  } psic_op_t;

endpackage : psic_pkg

/* psic_decode_model.sv */
// Partner model: decode side that drives the core command port.
// Assumes the bench changes cmd, arg and rfi just after a rising edge.
`timescale 1ns/1ns
module psic_decode_model
  import psic_pkg::*;
(
  input wire psic_pkg::psic_op_t cmd,
  input wire logic [psic_pkg::TARGET_W-1:0] arg,
  input wire logic rfi,
  output logic core_step,
  output logic core_call,
  output logic core_jump,
  output logic core_return,
  output logic core_return_from_interrupt,
  output logic core_vector,
  output logic [psic_pkg::TARGET_W-1:0] core_target,
  output logic [psic_pkg::DATA_W-1:0] core_pcl_data,
  output logic core_pcl_we
);
  // One command per cycle, decoded from the requested operation
  assign core_vector = (cmd == OP_VECTOR);
  assign core_call = (cmd == OP_CALL);
  assign core_jump = (cmd == OP_JUMP);
  assign core_return = (cmd == OP_RET) && !rfi;
  assign core_return_from_interrupt = (cmd == OP_RET) && rfi;
  assign core_pcl_we = (cmd == OP_PCL);
  assign core_step = (cmd == OP_STEP);
  // Operands; the run task inverts arg once its command is done
  assign core_target = arg;
  assign core_pcl_data = arg[7:0];
endmodule : psic_decode_model

/* pc_stack_interrupt_control_test.sv */
// Self-checking bench for the program counter, stack and interrupts.
// Assumes psic_pkg, psic_core and psic_decode_model compiled first.
`timescale 1ns/1ns
module pc_stack_interrupt_control_test;
  import psic_pkg::*;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic irq_request, rfi, timer_overflow_event, ext_pin_event;
  logic pin_change_event, core_step, core_call, core_jump, core_vector;
  logic core_return, core_return_from_interrupt, core_pcl_we;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic [7:0] periph_events, c, pf, pe, core_pcl_data;
  logic [12:0] pc, exp_pc;
  logic [12:0] stk [8];
  logic [2:0] sp;
  logic [4:0] latch;
  logic [10:0] arg, core_target, t;
  psic_op_t cmd;
  int errors, checks;
  logic [7:0] tc [4] = '{8'hA4, 8'h24, 8'hC0, 8'h80};

  psic_core i_psic_core (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .core_step(core_step), .core_call(core_call),
    .core_jump(core_jump), .core_return(core_return),
    .core_return_from_interrupt(core_return_from_interrupt),
    .core_vector(core_vector), .core_target(core_target),
    .core_pcl_we(core_pcl_we), .core_pcl_data(core_pcl_data),
    .timer_overflow_event(timer_overflow_event),
    .ext_pin_event(ext_pin_event), .pin_change_event(pin_change_event),
    .periph_events(periph_events), .pc(pc), .irq_request(irq_request));

  psic_decode_model i_psic_decode_model (.cmd(cmd), .arg(arg), .rfi(rfi),
    .core_step(core_step), .core_call(core_call), .core_jump(core_jump),
    .core_return(core_return), .core_vector(core_vector),
    .core_return_from_interrupt(core_return_from_interrupt),
    .core_target(core_target), .core_pcl_data(core_pcl_data),
    .core_pcl_we(core_pcl_we));

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  initial begin
    #2000000;
    errors++;
    end_of_test();
  end

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Avalon request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'h0};
    avs_writedata <= {24'h0, wd};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    rdata = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (n >= 50) errors++;
  endtask : bus

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'h0, idx, 8'h00);
    check(rdata, {24'h0, exp});
  endtask : rd_chk

  function automatic logic exp_req(input logic [7:0] k,
                                   input logic [7:0] f, input logic [7:0] e);
    return k[7] & ((k[5] & k[2]) | (k[4] & k[1]) | (k[3] & k[0]) |
                   (k[6] & |(f & e)));
  endfunction : exp_req

  // Issue one core command, update the stack model, compare pc
  task automatic run(input psic_op_t o, input logic [10:0] a,
                     input logic f);
    @(posedge clk);
    cmd <= o;
    arg <= a;
    rfi <= f;
    @(posedge clk);
    cmd <= OP_NONE;
    arg <= ~a;
    #1;
    case (o)
      OP_VECTOR, OP_CALL: begin
        stk[sp] = exp_pc;
        sp = sp + 3'h1;
        exp_pc = (o == OP_CALL) ? {2'h0, a} : IRQ_VECTOR_ADDR;
      end
      OP_JUMP: exp_pc = {2'h0, a};
      OP_RET: begin
        sp = sp - 3'h1;
        exp_pc = stk[sp];
      end
      OP_PCL: exp_pc = {latch, a[7:0]};
      OP_STEP: exp_pc = exp_pc + 13'h1;
      default: ;
    endcase
    check({19'h0, pc}, {19'h0, exp_pc});
  endtask : run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(74536));
    {avs_read, avs_write, rfi, timer_overflow_event} = 4'h0;
    {ext_pin_event, pin_change_event} = 2'h0;
    avs_address = 10'h000;
    avs_writedata = 32'h0;
    periph_events = 8'h00;
    cmd = OP_NONE;
    arg = 11'h000;
    sp = 3'h0;
    exp_pc = RST_PC;
    rst_n = 1'h0;
    repeat (16) @(posedge clk);
    check({19'h0, pc}, 32'h0);
    rst_n <= 1'h1;
    rd_chk(IDX_INTERRUPT_CONTROL, RST_INTERRUPT_CONTROL);
    rd_chk(IDX_PERIPHERAL_IRQ_FLAGS, RST_PERIPHERAL_IRQ_FLAGS);
    rd_chk(IDX_PERIPHERAL_IRQ_ENABLES, RST_PERIPHERAL_IRQ_ENABLES);
    // Program counter loads through the high latch
    latch = 5'h1F;
    bus(1'h1, IDX_PC_HIGH_LATCH, 8'h1F);
    bus(1'h1, IDX_PC_LOW, 8'hAB);
    repeat (2) @(posedge clk);
    #1;
    exp_pc = 13'h1FAB;
    check({19'h0, pc}, 32'h1FAB);
    rd_chk(IDX_PC_LOW, 8'hAB);
    run(OP_PCL, 11'($urandom), 1'h0);
    run(OP_JUMP, 11'($urandom), 1'h0);
    run(OP_STEP, 11'h000, 1'h0);
    // Ten calls wrap the eight-entry stack, then ten returns
    for (int i = 0; i < 10; i++) begin
      t = 11'($urandom);
      run(OP_CALL, t, 1'h0);
    end
    for (int i = 0; i < 10; i++)
      run(OP_RET, 11'($urandom), 1'h0);
    // Call followed at once by a return restores the counter
    t = 11'($urandom);
    stk[sp] = exp_pc;
    @(posedge clk);
    cmd <= OP_CALL;
    arg <= t;
    @(posedge clk);
    cmd <= OP_RET;
    rfi <= 1'h0;
    #1;
    check({19'h0, pc}, {21'h0, t});
    @(posedge clk);
    cmd <= OP_NONE;
    #1;
    check({19'h0, pc}, {19'h0, exp_pc});
    rd_chk(IDX_PC_HIGH_LATCH, 8'h1F);
    // Flags set with every enable clear, request stays low
    @(posedge clk);
    {timer_overflow_event, ext_pin_event, pin_change_event} <= 3'h7;
    periph_events <= 8'h81;
    @(posedge clk);
    {timer_overflow_event, ext_pin_event, pin_change_event} <= 3'h0;
    periph_events <= 8'h00;
    rd_chk(IDX_INTERRUPT_CONTROL, 8'h07);
    rd_chk(IDX_PERIPHERAL_IRQ_FLAGS, 8'h81);
    check({31'h0, irq_request}, 32'h0);
    bus(1'h1, IDX_INTERRUPT_CONTROL, 8'h00);
    bus(1'h1, IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
    // Enable combinations: corner table first, then random
    for (int i = 0; i < 16; i++) begin
      c = (i < 4) ? tc[i] : 8'($urandom);
      pf = (i < 4) ? 8'h01 : 8'($urandom);
      pe = (i < 4) ? 8'h01 : 8'($urandom);
      bus(1'h1, IDX_PERIPHERAL_IRQ_ENABLES, pe);
      bus(1'h1, IDX_PERIPHERAL_IRQ_FLAGS, pf);
      bus(1'h1, IDX_INTERRUPT_CONTROL, c);
      repeat (2) @(posedge clk);
      check({31'h0, irq_request}, {31'h0, exp_req(c, pf, pe)});
      rd_chk(IDX_INTERRUPT_CONTROL, c);
    end
    // Vectoring and return from interrupt, with event interrupt
    bus(1'h1, IDX_INTERRUPT_CONTROL, 8'h80);
    bus(1'h1, IDX_EVENT_MASK, 8'h03);
    run(OP_VECTOR, 11'($urandom), 1'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    rd_chk(IDX_INTERRUPT_CONTROL, 8'h00);
    run(OP_RET, 11'($urandom), 1'h1);
    rd_chk(IDX_INTERRUPT_CONTROL, 8'h80);
    rd_chk(IDX_EVENT_STATUS, 8'h03);
    bus(1'h1, IDX_EVENT_MASK, 8'h00);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'h1, IDX_EVENT_STATUS, 8'h03);
    rd_chk(IDX_EVENT_STATUS, 8'h00);
    // Unmapped place reads zero and ignores writes
    bus(1'h1, 8'h55, 8'hFF);
    rd_chk(8'h55, 8'h00);
    // Reset in mid-run clears the counter
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    #1;
    check({19'h0, pc}, 32'h0);
    @(posedge clk);
    rst_n <= 1'h1;
    sp = RST_SP;
    exp_pc = RST_PC;
    latch = RST_PC_HIGH_LATCH;
    // First edge after release: idle bus, counter still clear
    @(posedge clk);
    #1;
    check({18'h0, avs_waitrequest, pc}, {19'h1, RST_PC});
    rd_chk(IDX_INTERRUPT_CONTROL, RST_INTERRUPT_CONTROL);
    rd_chk(IDX_PC_HIGH_LATCH, 8'h00);
    run(OP_STEP, 11'h000, 1'h0);
    end_of_test();
  end
endmodule : pc_stack_interrupt_control_test
